// ### hdl/piu_pkg.sv
// Package with constants and types for the prioritized interrupt unit.
package piu_pkg;
  localparam logic [7:0] ADDR_OPTION = 8'hc8;
  localparam logic [7:0] ADDR_STATUS = 8'he0;
  localparam logic [7:0] ADDR_EVENTS = 8'he4;
  localparam logic [7:0] OPTION_RESET = 8'h00;
  localparam int BIT_LEVEL_EDGE = 6;
  localparam int BIT_EDGE_POL = 5;
  localparam int BIT_GLOBAL_EN = 4;
  localparam logic [11:0] VEC_NMI = 12'hffc;
  localparam logic [11:0] VEC_SRC1 = 12'hff6;
  localparam logic [11:0] VEC_SRC2 = 12'hff4;
  localparam logic [11:0] VEC_SRC3 = 12'hff2;
  localparam logic [11:0] VEC_SRC4 = 12'hff0;
  localparam int DEFECT_CYCLES = 3;
  localparam int NUM_EVENTS = 8;
  // Source served by each peripheral event flag, index 0 to 7.
  localparam logic [15:0] EVENT_SOURCE_MAP = 16'hffa5;

  typedef struct packed {
    logic unused7;
    logic level_edge_select;
    logic edge_polarity_select;
    logic global_int_enable;
    logic [3:0] unused_low;
  } piu_option_t;

  typedef enum logic [1:0] {
    PIU_MODE_NORMAL = 2'h0,
    PIU_MODE_IRQ = 2'h1,
    PIU_MODE_NMI = 2'h2
  } piu_mode_t;

  typedef enum logic [2:0] {
    PIU_IDLE = 3'h0,
    PIU_SWAP = 3'h1,
    PIU_PUSH = 3'h3,
    PIU_INHIBIT = 3'h2,
    PIU_CLEAR = 3'h6,
    PIU_LOAD = 3'h7
  } piu_state_t;

  typedef struct packed {
    logic carry;
    logic zero;
  } piu_flags_t;
endpackage

// ### hdl/piu_unit.sv
// Prioritized interrupt unit with option register, latches, entry sequencer and flag banks.
`timescale 1ns/1ps
// Operation
// R01 - Four maskable sources plus one non-maskable
// R02 - Taken source loads its fixed vector
// R03 - NMI preempts anything; maskable never nests (code does not take an NMI while already in NMI mode)
// R04 - Fixed priority, source 1 highest
// R05 - Global enable masks sources and gates wake
// R06 - NMI latched, cleared on NMI entry
// R07 - Source 1 level or falling edge
// R08 - Source 2 edge, polarity selectable
// R09 - Sources 3 and 4 level only
// R10 - Edge latch holds one pending request
// R11 - Level requests sampled, never stored
// R12 - Requests sampled at instruction end
// R13 - Three carry/zero pairs switched automatically
// R14 - Ordered five-step hardware entry sequence
// R15 - Option-clear race keeps normal flags
// R16 - Shared events have own readable flags
// R17 - Service software saves, polls, returns
// R18 - Option register write-only, no bit ops
// R19 - Option bits 6,5,4; reset zero
// R20 - One-cycle resolution, losers stay pending
module piu_unit #(
  parameter bit KEEP_FLAG_DEFECT = 1'b0
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic NMI_N,
  input wire logic [4:1] SRC_PIN_N,
  input wire logic [piu_pkg::NUM_EVENTS-1:0] EVENT_PULSE,
  input wire logic INSTR_END,
  input wire logic RETURN_FROM_INTERRUPT,
  input wire logic OPTION_CLEAR_EARLY,
  input wire logic FLAG_WE,
  input wire logic ALU_CARRY,
  input wire logic ALU_ZERO,
  output logic ENTRY_BUSY,
  output logic PC_PUSH,
  output logic VECTOR_LOAD,
  output logic [11:0] VECTOR_ADDR,
  output logic [1:0] INT_MODE,
  output logic CARRY_OUT,
  output logic ZERO_OUT,
  output logic WAKE
);
  piu_pkg::piu_option_t opt_q;
  piu_pkg::piu_state_t state_q;
  piu_pkg::piu_state_t state_d;
  piu_pkg::piu_mode_t mode_q;
  piu_pkg::piu_mode_t saved_mode_q;
  logic [1:0] pair_q;
  logic [1:0] saved_pair_q;
  piu_pkg::piu_flags_t bank_q [0:2];
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic [4:0] pin_prev_q;
  logic nmi_lat_q;
  logic [2:1] edge_lat_q;
  logic [piu_pkg::NUM_EVENTS-1:0] evt_q;
  logic [2:0] sel_q;
  logic defect_q;
  logic [31:0] rdata_q;
  logic wait_q;
  logic busy_q;
  logic push_q;
  logic load_q;
  logic wake_q;
  logic [11:0] vec_q;
  piu_pkg::piu_flags_t cz_q;

  // Vector of a source, 0 is the non-maskable one.
  function automatic logic [11:0] vector_of(input logic [2:0] src);
    logic [11:0] v;
    v = piu_pkg::VEC_SRC4;
    unique case (src)
      3'h0: v = piu_pkg::VEC_NMI;
      3'h1: v = piu_pkg::VEC_SRC1;
      3'h2: v = piu_pkg::VEC_SRC2;
      3'h3: v = piu_pkg::VEC_SRC3;
      default: v = piu_pkg::VEC_SRC4;
    endcase
    return v;
  endfunction

  // Event flags pulling each source line low while set.
  function automatic logic [4:1] events_on_sources(input logic [7:0] flags);
    logic [4:1] hit;
    hit = 4'h0;
    for (int i = 0; i < piu_pkg::NUM_EVENTS; i++) begin
      if (flags[i]) begin
        hit[3'(piu_pkg::EVENT_SOURCE_MAP[2*i +: 2]) + 3'h1] = 1'b1;
      end
    end
    return hit;
  endfunction

  // Bus decode.
  wire bus_req = (AVS_READ | AVS_WRITE) & wait_q;
  wire bus_done = ~wait_q;
  // Writes land on the edge that ends the access, where the master sees waitrequest low.
  wire wr_option = AVS_WRITE & bus_done & (AVS_ADDRESS == piu_pkg::ADDR_OPTION);
  wire wr_events = AVS_WRITE & bus_done & (AVS_ADDRESS == piu_pkg::ADDR_EVENTS);
  wire [31:0] status_word = {20'h0, defect_q, nmi_lat_q, edge_lat_q,
                             2'(saved_mode_q), 2'(mode_q), 2'(pair_q), 2'h0};
  wire [31:0] rdata_d = (AVS_ADDRESS == piu_pkg::ADDR_STATUS) ? status_word :
                        (AVS_ADDRESS == piu_pkg::ADDR_EVENTS) ?
                        {24'h0, evt_q} : 32'h0;

  // Request lines, pins after two flops, low when active.
  wire [4:1] line_n = pin_s2_q[4:1] & ~events_on_sources(evt_q); // R16
  wire [4:1] line_prev_n = pin_prev_q[4:1];
  wire fall1 = line_prev_n[1] & ~line_n[1];
  wire fall2 = line_prev_n[2] & ~line_n[2];
  wire rise2 = ~line_prev_n[2] & line_n[2];
  wire nmi_fall = pin_prev_q[0] & ~pin_s2_q[0];
  wire edge1 = ~opt_q.level_edge_select & fall1; // R07
  wire edge2 = opt_q.edge_polarity_select ? rise2 : fall2; // R08
  wire [4:1] req;
  assign req[1] = opt_q.level_edge_select ? ~line_n[1] : edge_lat_q[1]; // R07 R11
  assign req[2] = edge_lat_q[2]; // R08 R10
  assign req[3] = ~line_n[3]; // R09 R11
  assign req[4] = ~line_n[4]; // R09 R11

  // Maskable sources only in normal mode with global enable; NMI unless already in NMI.
  wire mask_ok = opt_q.global_int_enable & (mode_q == piu_pkg::PIU_MODE_NORMAL); // R03 R05
  wire nmi_ok = nmi_lat_q & (mode_q != piu_pkg::PIU_MODE_NMI); // R03
  wire [4:1] req_en = req & {4{mask_ok}}; // R01
  wire take = (state_q == piu_pkg::PIU_IDLE) & INSTR_END & (nmi_ok | (|req_en)); // R12
  // The NMI beats every maskable source; losers stay latched or asserted for later.
  wire [2:0] winner = nmi_ok ? 3'h0 : req_en[1] ? 3'h1 : req_en[2] ? 3'h2 :
                      req_en[3] ? 3'h3 : 3'h4; // R04 R20
  // The defect path sits behind a parameter so that the repaired behaviour is the default.
  wire race = KEEP_FLAG_DEFECT & OPTION_CLEAR_EARLY & (winner != 3'h0); // R15
  wire in_swap = state_q == piu_pkg::PIU_SWAP;
  wire in_clear = state_q == piu_pkg::PIU_CLEAR;
  wire clr_nmi = in_clear & (sel_q == 3'h0); // R06
  wire [2:1] clr_edge = {in_clear & (sel_q == 3'h2), in_clear & (sel_q == 3'h1)}; // R10
  wire [1:0] pair_now = (sel_q == 3'h0) ? 2'(piu_pkg::PIU_MODE_NMI) :
                        (defect_q ? 2'(piu_pkg::PIU_MODE_NORMAL) :
                        2'(piu_pkg::PIU_MODE_IRQ)); // R13 R15
  // Wake ignores the mode, so a pending request can restart a halted core.
  wire any_wake_src = nmi_lat_q | (|req);
  wire [1:0] pair_next = in_swap ? pair_now :
                         RETURN_FROM_INTERRUPT ? saved_pair_q : pair_q;

  // Entry sequence: swap flags, push PC, inhibit, clear latch, load vector.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      piu_pkg::PIU_IDLE: if (take) state_d = piu_pkg::PIU_SWAP;
      piu_pkg::PIU_SWAP: state_d = piu_pkg::PIU_PUSH; // R14
      piu_pkg::PIU_PUSH: state_d = piu_pkg::PIU_INHIBIT; // R14
      piu_pkg::PIU_INHIBIT: state_d = piu_pkg::PIU_CLEAR; // R14
      piu_pkg::PIU_CLEAR: state_d = piu_pkg::PIU_LOAD; // R14
      piu_pkg::PIU_LOAD: state_d = piu_pkg::PIU_IDLE; // R14
      default: state_d = piu_pkg::PIU_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      state_q <= piu_pkg::PIU_IDLE;
      sel_q <= 3'h0;
      defect_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (take) begin
        sel_q <= winner;
        defect_q <= race;
      end
    end
  end

  // Pin synchronisers and the previous synchronised level for edge detection.
  // They reset to the idle high level, so no false edge follows reset.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      pin_s1_q <= 5'h1f;
      pin_s2_q <= 5'h1f;
      pin_prev_q <= 5'h1f;
    end else begin
      pin_s1_q <= {SRC_PIN_N, NMI_N};
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= {line_n, pin_s2_q[0]};
    end
  end

  // Latches: a new edge wins over a clear in the same cycle.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      nmi_lat_q <= 1'b0;
      edge_lat_q <= 2'h0;
      evt_q <= '0;
    end else begin
      nmi_lat_q <= nmi_fall | (nmi_lat_q & ~clr_nmi); // R06
      // Level mode on source 1 also drops any stale edge latch.
      edge_lat_q[1] <= edge1 | (edge_lat_q[1] & ~clr_edge[1] & ~opt_q.level_edge_select); // R10
      edge_lat_q[2] <= edge2 | (edge_lat_q[2] & ~clr_edge[2]); // R10
      evt_q <= EVENT_PULSE | (evt_q & ~(wr_events ? AVS_WRITEDATA[7:0] : 8'h00)); // R16
    end
  end

  // Interrupt mode; a return restores the mode that an NMI preempted.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      mode_q <= piu_pkg::PIU_MODE_NMI;
      saved_mode_q <= piu_pkg::PIU_MODE_NORMAL;
    end else begin
      if (state_q == piu_pkg::PIU_INHIBIT) begin
        mode_q <= (sel_q == 3'h0) ? piu_pkg::PIU_MODE_NMI : piu_pkg::PIU_MODE_IRQ; // R14
        saved_mode_q <= mode_q;
      end else if (RETURN_FROM_INTERRUPT) begin
        mode_q <= saved_mode_q; // R13
        saved_mode_q <= piu_pkg::PIU_MODE_NORMAL;
      end
    end
  end

  // Active flag pair; one level of preemption is remembered, as for the mode.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      pair_q <= 2'(piu_pkg::PIU_MODE_NMI);
      saved_pair_q <= 2'(piu_pkg::PIU_MODE_NORMAL);
    end else begin
      if (in_swap) begin
        saved_pair_q <= pair_q;
      end else if (RETURN_FROM_INTERRUPT) begin
        saved_pair_q <= 2'(piu_pkg::PIU_MODE_NORMAL);
      end
      pair_q <= pair_next; // R13
    end
  end

  // Flag banks; the outputs follow the pair that is active in the next cycle.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      for (int i = 0; i < 3; i++) begin
        bank_q[i] <= '0;
      end
      cz_q <= '0;
    end else begin
      if (FLAG_WE) begin
        bank_q[pair_q] <= {ALU_CARRY, ALU_ZERO};
        cz_q <= {ALU_CARRY, ALU_ZERO};
      end else begin
        cz_q <= bank_q[pair_next]; // R13
      end
    end
  end

  // Option register and bus handshake.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      opt_q <= piu_pkg::OPTION_RESET; // R19
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      if (wr_option) begin
        opt_q <= {1'b0, AVS_WRITEDATA[piu_pkg::BIT_LEVEL_EDGE],
                  AVS_WRITEDATA[piu_pkg::BIT_EDGE_POL],
                  AVS_WRITEDATA[piu_pkg::BIT_GLOBAL_EN], 4'h0}; // R18 R19
      end
      wait_q <= ~bus_req | bus_done;
      rdata_q <= (AVS_READ & bus_req) ? rdata_d : 32'h0; // R18
    end
  end

  // Core-facing outputs, registered; PC_PUSH and VECTOR_LOAD reach the core as clean single-cycle pulses.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      busy_q <= 1'b0;
      push_q <= 1'b0;
      load_q <= 1'b0;
      vec_q <= 12'h0;
      wake_q <= 1'b0;
    end else begin
      busy_q <= (state_d != piu_pkg::PIU_IDLE);
      push_q <= (state_d == piu_pkg::PIU_PUSH); // R14
      load_q <= (state_d == piu_pkg::PIU_LOAD); // R14
      if (state_q == piu_pkg::PIU_CLEAR) begin
        vec_q <= vector_of(sel_q); // R02
      end
      wake_q <= opt_q.global_int_enable & any_wake_src; // R05
    end
  end

  assign AVS_READDATA = rdata_q;
  assign AVS_WAITREQUEST = wait_q;
  assign ENTRY_BUSY = busy_q;
  assign PC_PUSH = push_q;
  assign VECTOR_LOAD = load_q;
  assign VECTOR_ADDR = vec_q;
  assign INT_MODE = 2'(mode_q);
  assign CARRY_OUT = cz_q.carry;
  assign ZERO_OUT = cz_q.zero;
  assign WAKE = wake_q;
endmodule

// ### tb/piu_assertions.sv
// Checker for the interrupt unit bus and entry sequence.
`timescale 1ns/1ps
module piu_chk (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic INSTR_END,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic ENTRY_BUSY,
  input wire logic PC_PUSH,
  input wire logic VECTOR_LOAD,
  input wire logic [11:0] VECTOR_ADDR,
  input wire logic [1:0] INT_MODE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  sequence steps_s;
    PC_PUSH ##3 VECTOR_LOAD ##1 !ENTRY_BUSY;
  endsequence
  entry_order_a: assert property ($rose(ENTRY_BUSY) |=> steps_s)
    else $error("entry steps out of order");
  entry_cause_a: assert property ($rose(ENTRY_BUSY) |-> $past(INSTR_END))
    else $error("entry without instruction end");
  push_once_a: assert property (PC_PUSH |=> !PC_PUSH && ENTRY_BUSY)
    else $error("push not a single step");
  vec_legal_a: assert property (VECTOR_LOAD |-> VECTOR_ADDR inside {12'hffc, 12'hff6,
    12'hff4, 12'hff2, 12'hff0}) else $error("vector outside table");
  nmi_mode_a: assert property (VECTOR_LOAD && VECTOR_ADDR == 12'hffc |-> INT_MODE == 2'h2)
    else $error("nmi entry without nmi mode");
  irq_mode_a: assert property (VECTOR_LOAD && VECTOR_ADDR != 12'hffc |-> INT_MODE == 2'h1)
    else $error("maskable entry without irq mode");
  no_nest_a: assert property ($rose(ENTRY_BUSY) && $past(INT_MODE) == 2'h1
    |-> ##4 VECTOR_LOAD && VECTOR_ADDR == 12'hffc) else $error("maskable nested");
  wait_one_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  bus_answer_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
    |=> !AVS_WAITREQUEST) else $error("bus access not answered");
  opt_read_a: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 8'hc8
    |-> AVS_READDATA == 32'h0) else $error("option register readable");
endmodule
bind piu_unit piu_chk u_chk (.CLK_SYS, .RESET, .INSTR_END, .AVS_READ, .AVS_WRITE,
  .AVS_ADDRESS, .AVS_READDATA, .AVS_WAITREQUEST, .ENTRY_BUSY, .PC_PUSH, .VECTOR_LOAD,
  .VECTOR_ADDR, .INT_MODE);

// ### tb/piu_core_model.sv
// Core model that marks instruction ends and executes returns.
`timescale 1ns/1ps
module piu_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] gap,
  input wire logic ret_req,
  input wire logic busy,
  output logic instr_end,
  output logic ret
);
  logic [3:0] cnt_q;
  // The core is stalled during entry, so no boundary is offered then.
  always_ff @(posedge clk) begin
    if (rst || busy) begin
      cnt_q <= 4'h0;
      instr_end <= 1'b0;
      ret <= 1'b0;
    end else begin
      cnt_q <= (cnt_q >= gap) ? 4'h0 : cnt_q + 4'h1;
      instr_end <= (cnt_q >= gap);
      ret <= ret_req;
    end
  end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the interrupt unit.
`timescale 1ns/1ps
module tb_top;
  logic CLK_SYS = 1'b0, RESET = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0, NMI_N = 1'b1;
  logic [7:0] AVS_ADDRESS = 8'h00, EVENT_PULSE = 8'h00;
  logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, q;
  logic [4:1] SRC_PIN_N = 4'hf;
  logic FLAG_WE = 1'b0, ALU_CARRY = 1'b0, ALU_ZERO = 1'b0, ret_req = 1'b0, opt_early = 1'b0;
  logic AVS_WAITREQUEST, ENTRY_BUSY, VECTOR_LOAD, CARRY_OUT, ZERO_OUT, WAKE, INSTR_END, RFI;
  logic [11:0] VECTOR_ADDR;
  logic [1:0] INT_MODE;
  int num_errors = 0, checks = 0, nvec = 0, cyc = 0;
  always #2 CLK_SYS = ~CLK_SYS;
  piu_unit DUT (.CLK_SYS, .RESET, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
    .AVS_READDATA, .AVS_WAITREQUEST, .NMI_N, .SRC_PIN_N, .EVENT_PULSE, .INSTR_END,
    .RETURN_FROM_INTERRUPT(RFI), .OPTION_CLEAR_EARLY(opt_early), .FLAG_WE, .ALU_CARRY,
    .ALU_ZERO,
    .ENTRY_BUSY, .PC_PUSH(), .VECTOR_LOAD, .VECTOR_ADDR, .INT_MODE, .CARRY_OUT, .ZERO_OUT, .WAKE);
  piu_core_model core (.clk(CLK_SYS), .rst(RESET), .gap(4'h3), .ret_req(ret_req),
    .busy(ENTRY_BUSY), .instr_end(INSTR_END), .ret(RFI));
  always @(posedge CLK_SYS) begin
    if (VECTOR_LOAD === 1'b1) nvec <= nvec + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    AVS_READ <= !w;
    AVS_WRITE <= w;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    do begin
      @(posedge CLK_SYS);
    end while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  task automatic expect_vec(input logic [11:0] v, input logic [1:0] m);
    do begin
      @(posedge CLK_SYS);
    end while (VECTOR_LOAD !== 1'b1);
    chk("vector", {20'h0, v}, {20'h0, VECTOR_ADDR});
    chk("mode", {30'h0, m}, {30'h0, INT_MODE});
  endtask
  task automatic do_ret;
    @(posedge CLK_SYS);
    ret_req <= 1'b1;
    @(posedge CLK_SYS);
    ret_req <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
  endtask
  task automatic pin(input logic [4:1] v);
    SRC_PIN_N <= v;
    repeat (6) @(posedge CLK_SYS);
  endtask
  task automatic conclude;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge CLK_SYS);
    RESET <= 1'b0;
    bus(1'b0, piu_pkg::ADDR_OPTION, 32'h0);
    chk("option", 32'h0, q);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b0, piu_pkg::ADDR_STATUS, 32'h0);
    chk("status", 32'h28, q);
    do_ret();
    {ALU_CARRY, ALU_ZERO} <= 2'h3;
    FLAG_WE <= 1'b1;
    pin(4'h3);
    FLAG_WE <= 1'b0;
    repeat (20) @(posedge CLK_SYS);
    chk("masked", 32'h0, nvec);
    chk("wake", 32'h0, {31'h0, WAKE});
    opt_early <= 1'b1;
    bus(1'b1, piu_pkg::ADDR_OPTION, 32'h10);
    expect_vec(piu_pkg::VEC_SRC3, 2'h1);
    chk("irq pair", 32'h0, {30'h0, CARRY_OUT, ZERO_OUT});
    chk("wake on", 32'h1, {31'h0, WAKE});
    opt_early <= 1'b0;
    NMI_N <= 1'b0;
    repeat (6) @(posedge CLK_SYS);
    NMI_N <= 1'b1;
    expect_vec(piu_pkg::VEC_NMI, 2'h2);
    do_ret();
    chk("back to irq", 32'h1, {30'h0, INT_MODE});
    pin(4'h7);
    do_ret();
    expect_vec(piu_pkg::VEC_SRC4, 2'h1);
    pin(4'hf);
    bus(1'b1, piu_pkg::ADDR_OPTION, 32'h30);
    pin(4'hd);
    pin(4'hf);
    pin(4'hd);
    pin(4'hf);
    do_ret();
    expect_vec(piu_pkg::VEC_SRC2, 2'h1);
    do_ret();
    repeat (20) @(posedge CLK_SYS);
    chk("entries", 32'h4, nvec);
    bus(1'b1, piu_pkg::ADDR_OPTION, 32'h10);
    SRC_PIN_N <= 4'he;
    repeat (2) @(posedge CLK_SYS);
    SRC_PIN_N <= 4'hf;
    expect_vec(piu_pkg::VEC_SRC1, 2'h1);
    do_ret();
    bus(1'b1, piu_pkg::ADDR_OPTION, 32'h50);
    pin(4'he);
    expect_vec(piu_pkg::VEC_SRC1, 2'h1);
    pin(4'hf);
    do_ret();
    repeat (3) @(posedge CLK_SYS);
    chk("normal pair", 32'h3, {30'h0, CARRY_OUT, ZERO_OUT});
    bus(1'b1, piu_pkg::ADDR_OPTION, 32'h0);
    EVENT_PULSE <= 8'h04;
    @(posedge CLK_SYS);
    EVENT_PULSE <= 8'h00;
    bus(1'b0, piu_pkg::ADDR_EVENTS, 32'h0);
    chk("event flag", 32'h4, q);
    bus(1'b1, piu_pkg::ADDR_EVENTS, 32'h4);
    bus(1'b0, piu_pkg::ADDR_EVENTS, 32'h0);
    chk("event clear", 32'h0, q);
    conclude();
  end
endmodule
